/* File: inc/fhc_defines.svh */
// Functional notes
// [R1] Data is driven by the memory only while chip select and output gate are low.
// [R2] A write needs chip select and write strobe low with output gate high.
// [R3] Memory captures address when the later of write strobe or chip select falls.
// [R4] Memory captures data when the earlier of write strobe or chip select rises.
// [R5] Output gate and write strobe high leave the data pins floating.
// [R6] Chip select high with the controller idle puts the memory in standby.
// [R7] After idle bus time with steady address, memory enters pseudo-standby, still driving.
// [R8] High voltage on signature address bit with query bit low reads maker or part code.
// [R9] Identification codes are also readable after the auto-select instruction.
// [R10] Protect: high voltage on signature bit and output gate, strobe low, hold protect delay.
// [R11] Protect-verify read returns one for a protected block.
// [R12] Program or erase of a protected block is silently ignored.
// [R13] High voltage on reset pin temporarily unprotects all blocks.
// [R14] Protect every block first; unprotect with keys high, fixed long delay.
// [R15] Unprotect-verify read returns zero per block; host checks each block.
// [R16] After auto-select, query bit high and code bit low reads block protect status.
// [R17] Each instruction spans one to six bus cycles, leading ones are writes.
// [R18] Invalid command combinations make the memory return to array read.
// [R19] Host issues command writes in exact order, starting with the unlock pair. Suspend and resume go out as a single write with no unlock pair.
// [R20] Every instruction starts with two unlock writes; erase confirm repeats them. The host sends suspend and resume as one plain write with no unlock.
// [R21] While busy, the memory refuses new program or erase instructions.
// [R22] Unlock pair is common to all instructions; third cycle is the set-up command. The host sends suspend and resume without the unlock pair.
// [R23] Each high-voltage level is a separate qualifier output alongside the pin.
`ifndef FHC_DEFINES_SVH
`define FHC_DEFINES_SVH
`define FHC_CLK_NS          10
`define FHC_SETUP_NS        30
`define FHC_SETUP_CYC       ((`FHC_SETUP_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_STROBE_NS       50
`define FHC_STROBE_CYC      ((`FHC_STROBE_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_ACCESS_NS       100
`define FHC_ACCESS_CYC      ((`FHC_ACCESS_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_PROTECT_US      100
`define FHC_PROTECT_CYC     ((`FHC_PROTECT_US * 1000 + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_UNPROTECT_MS    10
`define FHC_UNPROTECT_CYC   ((`FHC_UNPROTECT_MS * 1000000 + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_UNLOCK1_ADDR    19'h05555
`define FHC_UNLOCK2_ADDR    19'h02AAA
`define FHC_UNLOCK1_DATA    8'hAA
`define FHC_UNLOCK2_DATA    8'h55
`define FHC_CMD_READ        8'hF0
`define FHC_CMD_AUTOSEL     8'h90
`define FHC_CMD_PROGRAM     8'hA0
`define FHC_CMD_ERASE_SETUP 8'h80
`define FHC_CMD_CHIP_CONF   8'h10
`define FHC_CMD_BLOCK_CONF  8'h30
`define FHC_CMD_SUSPEND     8'hB0
`define FHC_BIT_CODE_SEL    0
`define FHC_BIT_PROT_QUERY  1
`define FHC_BIT_VERIFY_KIND 6
`define FHC_BIT_SIG_EN      9
`define FHC_BIT_KEY_LO      12
`define FHC_BIT_KEY_HI      15
`define FHC_BLOCK_LSB       13
`endif

/* File: inc/fhc_pkg.sv */
`default_nettype none
package fhc_pkg;
   typedef enum logic [3:0] {
      FHC_OP_READ, FHC_OP_WRITE, FHC_OP_RESET_ARRAY, FHC_OP_AUTOSEL, FHC_OP_PROGRAM,
      FHC_OP_CHIP_ERASE, FHC_OP_BLOCK_ERASE, FHC_OP_SUSPEND, FHC_OP_RESUME,
      FHC_OP_SIG_READ, FHC_OP_PROTECT, FHC_OP_UNPROTECT, FHC_OP_PROT_VERIFY, FHC_OP_UNPROT_VERIFY
   } fhc_op_e;
   typedef logic [18:0] fhc_addr_t;
   typedef logic [7:0]  fhc_byte_t;
   typedef logic [23:0] fhc_cnt_t;
endpackage
`default_nettype wire

/* File: core/fhc_cycle.sv */
`include "fhc_defines.svh"
`default_nettype none
// one bus cycle on the memory pins: read or write, timed by cycle counts
module fhc_cycle
   import fhc_pkg::*;
(
   // clock and reset
   input  wire logic      clock,
   input  wire logic      sys_rst,
   // request
   input  wire logic      go,
   input  wire logic      is_write,
   input  wire logic      gate_hv,
   input  wire logic      select_hv,
   input  wire fhc_cnt_t  hold_cyc,
   output logic           done,
   // pin side
   output logic           chip_sel_n,
   output logic           out_gate_n,
   output logic           wr_strobe_n,
   output logic           chip_sel_hv,
   output logic           out_gate_hv,
   output logic           byte_lanes_oe,
   output logic           sample
);
   typedef enum logic [1:0] {FHC_C_IDLE, FHC_C_SETUP, FHC_C_ACT, FHC_C_END} fhc_cst_e;
   typedef struct packed {
      fhc_cst_e  st;
      logic      wr;
      logic      ghv;
      logic      shv;
      fhc_cnt_t  cnt;
      fhc_cnt_t  hold;
   } fhc_cyc_s;
   fhc_cyc_s s_r, s_nxt;

   // sequencing: setup, strobe active, release
   always_comb begin
      s_nxt = s_r;
      unique case (s_r.st)
         FHC_C_IDLE: begin
            if (go) begin
               s_nxt.st   = FHC_C_SETUP;
               s_nxt.wr   = is_write;
               s_nxt.ghv  = gate_hv;
               s_nxt.shv  = select_hv;
               s_nxt.hold = hold_cyc;
               s_nxt.cnt  = fhc_cnt_t'(`FHC_SETUP_CYC);
            end
         end
         FHC_C_SETUP: begin
            s_nxt.cnt = s_r.cnt - 24'h000001;
            if (s_r.cnt == 24'h000001) begin
               s_nxt.st  = FHC_C_ACT;
               s_nxt.cnt = s_r.hold;
            end
         end
         FHC_C_ACT: begin
            s_nxt.cnt = s_r.cnt - 24'h000001;
            if (s_r.cnt == 24'h000001) begin
               s_nxt.st = FHC_C_END;
            end
         end
         FHC_C_END: s_nxt.st = FHC_C_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_r <= '{st: FHC_C_IDLE, wr: 1'b0, ghv: 1'b0, shv: 1'b0, cnt: 24'h000000, hold: 24'h000001};
      end else begin
         s_r <= s_nxt;
      end
   end

   // chip select low over setup, active and end; strobe only within it so address
   // latches on strobe fall and data on strobe rise
   assign chip_sel_n    = (s_r.st == FHC_C_IDLE);                       // [R6]
   assign wr_strobe_n   = !(s_r.wr && s_r.st == FHC_C_ACT);              // [R3] [R4]
   assign out_gate_n    = s_r.wr ? 1'b1 : !(s_r.st == FHC_C_ACT);        // [R2] [R1]
   assign out_gate_hv   = s_r.ghv && s_r.st != FHC_C_IDLE;               // [R23]
   assign chip_sel_hv   = s_r.shv && s_r.st != FHC_C_IDLE;               // [R23]
   assign byte_lanes_oe = s_r.wr && s_r.st != FHC_C_IDLE && !s_r.ghv;    // [R5]
   assign sample        = !s_r.wr && s_r.st == FHC_C_ACT && s_r.cnt == 24'h000001;
   assign done          = s_r.st == FHC_C_END;

   a_write_gate_high: assert property (@(posedge clock) disable iff (sys_rst) // [R2]
      !wr_strobe_n |-> out_gate_n && !chip_sel_n)
      else $error("write strobe low while gate low or chip deselected");
   a_read_both_low: assert property (@(posedge clock) disable iff (sys_rst) // [R1]
      sample |-> !out_gate_n && !chip_sel_n && $past(!out_gate_n))
      else $error("read sampled without select and gate");
endmodule
`default_nettype wire

/* File: core/fhc_host.sv */
`include "fhc_defines.svh"
`default_nettype none
// host controller: turns user operations into pin sequences for the flash
module fhc_host
   import fhc_pkg::*;
#(
   parameter fhc_cnt_t PROTECT_CYC   = fhc_cnt_t'(`FHC_PROTECT_CYC),
   parameter fhc_cnt_t UNPROTECT_CYC = fhc_cnt_t'(`FHC_UNPROTECT_CYC)
)
(
   // clock and reset
   input  wire logic      clock,
   input  wire logic      sys_rst,
   // user request
   input  wire logic      req_valid,
   output logic           req_ready,
   input  wire fhc_op_e   req_op,
   input  wire fhc_addr_t req_addr,
   input  wire fhc_byte_t req_data,
   input  wire logic      temp_unprotect,
   // user answer
   output logic           rsp_valid,
   output fhc_byte_t      rsp_data,
   output logic           busy,
   // memory pins
   output fhc_addr_t      addr,
   output logic           chip_sel_n,
   output logic           out_gate_n,
   output logic           wr_strobe_n,
   output fhc_byte_t      byte_lanes_o,
   output logic           byte_lanes_oe,
   input  wire fhc_byte_t byte_lanes_i,
   output logic           reset_unprotect_n,
   input  wire logic      busy_indicator_n,
   // high-voltage qualifiers
   output logic           sig_addr_hv,
   output logic           out_gate_hv,
   output logic           chip_sel_hv,
   output logic           reset_hv
);
   typedef enum logic [1:0] {FHC_H_IDLE, FHC_H_ISSUE, FHC_H_WAIT, FHC_H_DONE} fhc_hst_e;
   typedef struct packed {
      fhc_hst_e  st;
      fhc_op_e   op;
      logic [2:0] step;
      logic [2:0] nsteps;
      fhc_addr_t uaddr;
      fhc_byte_t udata;
      fhc_addr_t a;
      fhc_byte_t d;
      logic      wr;
      logic      hv_sig;
      logic      hv_gate;
      logic      hv_sel;
      fhc_cnt_t  hold;
      fhc_byte_t rd;
      logic      rvalid;
      logic [2:0] rb_sync;
      logic      busy_q;
   } fhc_host_s;
   fhc_host_s s_r, s_nxt;
   logic cyc_done;
   logic cyc_sample;

   // number of bus cycles an operation takes, reads included
   function automatic logic [2:0] op_len(input fhc_op_e op);
      unique case (op)
         FHC_OP_RESET_ARRAY, FHC_OP_AUTOSEL:  op_len = 3'd3;  // [R22]
         FHC_OP_PROGRAM:                      op_len = 3'd4;
         FHC_OP_CHIP_ERASE, FHC_OP_BLOCK_ERASE: op_len = 3'd6; // [R17]
         default:                             op_len = 3'd1;
      endcase
   endfunction

   // address, data and kind of one step of the unlocked command sequence
   function automatic logic [27:0] cmd_step(input fhc_op_e op, input logic [2:0] st,
                                            input fhc_addr_t ua, input fhc_byte_t ud);
      fhc_byte_t setup;
      setup = `FHC_CMD_READ;
      if (op == FHC_OP_AUTOSEL) setup = `FHC_CMD_AUTOSEL;
      if (op == FHC_OP_PROGRAM) setup = `FHC_CMD_PROGRAM;
      if (op == FHC_OP_CHIP_ERASE || op == FHC_OP_BLOCK_ERASE) setup = `FHC_CMD_ERASE_SETUP;
      unique case (st)
         3'd0, 3'd3: cmd_step = {1'b1, `FHC_UNLOCK1_ADDR, `FHC_UNLOCK1_DATA};   // [R20]
         3'd1, 3'd4: cmd_step = {1'b1, `FHC_UNLOCK2_ADDR, `FHC_UNLOCK2_DATA};   // [R20]
         3'd2:       cmd_step = {1'b1, `FHC_UNLOCK1_ADDR, setup};               // [R22]
         default:    cmd_step = {1'b1, ua, (op == FHC_OP_CHIP_ERASE) ? `FHC_CMD_CHIP_CONF
                                           : `FHC_CMD_BLOCK_CONF};
      endcase
      // program puts address and data on the fourth cycle
      if (op == FHC_OP_PROGRAM && st == 3'd3) cmd_step = {1'b1, ua, ud};
   endfunction

   // builds the pin settings for the current step
   always_comb begin
      logic [27:0] cs;
      fhc_addr_t   va;
      cs    = cmd_step(s_r.op, s_r.step, s_r.uaddr, s_r.udata);
      va    = s_r.uaddr;
      s_nxt = s_r;
      s_nxt.rvalid  = 1'b0;
      s_nxt.rb_sync = {s_r.rb_sync[1:0], busy_indicator_n};
      // a level change counts only once the last two stages agree
      if (s_r.rb_sync[2] == s_r.rb_sync[1]) begin
         s_nxt.busy_q = !s_r.rb_sync[1];                                  // [R21]
      end
      unique case (s_r.st)
         FHC_H_IDLE: begin
            if (req_valid) begin
               s_nxt.op     = req_op;
               s_nxt.uaddr  = req_addr;
               s_nxt.udata  = req_data;
               s_nxt.step   = 3'd0;
               s_nxt.nsteps = op_len(req_op);
               s_nxt.st     = FHC_H_ISSUE;
            end
         end
         FHC_H_ISSUE: begin
            s_nxt.hv_sig  = 1'b0;
            s_nxt.hv_gate = 1'b0;
            s_nxt.hv_sel  = 1'b0;
            s_nxt.hold    = fhc_cnt_t'(`FHC_STROBE_CYC);
            s_nxt.a       = cs[26:8];
            s_nxt.d       = cs[7:0];
            s_nxt.wr      = cs[27];
            unique case (s_r.op)
               FHC_OP_READ: begin
                  s_nxt.wr   = 1'b0;
                  s_nxt.a    = va;
                  s_nxt.hold = fhc_cnt_t'(`FHC_ACCESS_CYC);
               end
               FHC_OP_WRITE, FHC_OP_SUSPEND, FHC_OP_RESUME: begin
                  s_nxt.a = va;
                  s_nxt.d = (s_r.op == FHC_OP_SUSPEND) ? `FHC_CMD_SUSPEND
                          : (s_r.op == FHC_OP_RESUME) ? `FHC_CMD_BLOCK_CONF : s_r.udata;
               end
               FHC_OP_SIG_READ: begin                                     // [R8]
                  s_nxt.wr     = 1'b0;
                  s_nxt.hv_sig = 1'b1;
                  s_nxt.a      = va;
                  s_nxt.a[`FHC_BIT_PROT_QUERY] = 1'b0;
                  s_nxt.hold   = fhc_cnt_t'(`FHC_ACCESS_CYC);
               end
               FHC_OP_PROTECT: begin                                      // [R10]
                  s_nxt.wr      = 1'b1;
                  s_nxt.hv_sig  = 1'b1;
                  s_nxt.hv_gate = 1'b1;
                  s_nxt.a       = va;
                  s_nxt.hold    = PROTECT_CYC;
               end
               FHC_OP_UNPROTECT: begin                                    // [R14]
                  s_nxt.wr      = 1'b1;
                  s_nxt.hv_sig  = 1'b1;
                  s_nxt.hv_gate = 1'b1;
                  s_nxt.hv_sel  = 1'b1;
                  s_nxt.a       = va;
                  s_nxt.a[`FHC_BIT_KEY_LO] = 1'b1;
                  s_nxt.a[`FHC_BIT_KEY_HI] = 1'b1;
                  s_nxt.hold    = UNPROTECT_CYC;
               end
               FHC_OP_PROT_VERIFY, FHC_OP_UNPROT_VERIFY: begin            // [R11] [R15]
                  s_nxt.wr     = 1'b0;
                  s_nxt.hv_sig = 1'b1;
                  s_nxt.a      = va;
                  s_nxt.a[`FHC_BIT_CODE_SEL]    = 1'b0;
                  s_nxt.a[`FHC_BIT_PROT_QUERY]  = 1'b1;
                  s_nxt.a[`FHC_BIT_VERIFY_KIND] = (s_r.op == FHC_OP_UNPROT_VERIFY);
                  s_nxt.hold   = fhc_cnt_t'(`FHC_ACCESS_CYC);
               end
               default: ;
            endcase
            s_nxt.st = FHC_H_WAIT;
         end
         FHC_H_WAIT: begin
            if (cyc_sample) begin
               s_nxt.rd = byte_lanes_i;                                   // [R1]
            end
            if (cyc_done) begin
               s_nxt.step = s_r.step + 3'd1;
               s_nxt.st   = (s_r.step + 3'd1 >= s_r.nsteps) ? FHC_H_DONE : FHC_H_ISSUE; // [R19]
            end
         end
         FHC_H_DONE: begin
            s_nxt.rvalid = 1'b1;
            s_nxt.st     = FHC_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   fhc_cycle u_cycle (
      .clock         (clock),
      .sys_rst       (sys_rst),
      .go            (s_r.st == FHC_H_ISSUE),
      .is_write      (s_nxt.wr),
      .gate_hv       (s_nxt.hv_gate),
      .select_hv     (s_nxt.hv_sel),
      .hold_cyc      (s_nxt.hold),
      .done          (cyc_done),
      .chip_sel_n    (chip_sel_n),
      .out_gate_n    (out_gate_n),
      .wr_strobe_n   (wr_strobe_n),
      .chip_sel_hv   (chip_sel_hv),
      .out_gate_hv   (out_gate_hv),
      .byte_lanes_oe (byte_lanes_oe),
      .sample        (cyc_sample)
   );

   // pins come from registers; qualifiers held only while a cycle is underway, except reset_hv, which follows temp_unprotect
   assign addr              = s_r.a;
   assign byte_lanes_o      = s_r.d;
   assign sig_addr_hv       = s_r.hv_sig && s_r.st == FHC_H_WAIT;         // [R23]
   assign reset_unprotect_n = 1'b1;
   assign reset_hv          = temp_unprotect;                             // [R13]
   assign req_ready         = s_r.st == FHC_H_IDLE;
   assign rsp_valid         = s_r.rvalid;
   assign rsp_data          = s_r.rd;
   assign busy              = s_r.busy_q;                                 // [R21]

   a_unlock_first: assert property (@(posedge clock) disable iff (sys_rst) // [R20]
      $fell(wr_strobe_n) && s_r.step == 3'd0 && s_r.op == FHC_OP_PROGRAM
      |-> addr == `FHC_UNLOCK1_ADDR && byte_lanes_o == `FHC_UNLOCK1_DATA)
      else $error("first command write is not the unlock code");
   a_hv_sig_read: assert property (@(posedge clock) disable iff (sys_rst) // [R8]
      !out_gate_n && s_r.op == FHC_OP_SIG_READ |-> sig_addr_hv && !addr[`FHC_BIT_PROT_QUERY])
      else $error("signature read without high voltage qualifier");
   a_protect_gate: assert property (@(posedge clock) disable iff (sys_rst) // [R10]
      !wr_strobe_n && s_r.op == FHC_OP_PROTECT |-> out_gate_hv && sig_addr_hv)
      else $error("protect strobe without high voltage gate");
   a_unprotect_keys: assert property (@(posedge clock) disable iff (sys_rst) // [R14]
      !wr_strobe_n && s_r.op == FHC_OP_UNPROTECT
      |-> chip_sel_hv && out_gate_hv && addr[`FHC_BIT_KEY_LO] && addr[`FHC_BIT_KEY_HI])
      else $error("unprotect strobe without keys or high voltage select");
endmodule
`default_nettype wire

/* File: test/fhc_flash_model.sv */
`include "fhc_defines.svh"
`default_nettype none
// pin-level flash device: no clock, writes hang on strobe edges, reads follow the address and gate pins
module fhc_flash_model
   import fhc_pkg::*;
#(
   parameter fhc_byte_t MAKER_CODE = 8'h5A, // arbitrary value
   parameter fhc_byte_t PART_CODE  = 8'hC3, // arbitrary value
   parameter int        PROT_NS    = 200,
   parameter int        UNPROT_NS  = 200,
   parameter int        BUSY_NS    = 2000
)
(
   // pins
   input  wire fhc_addr_t addr,
   input  wire logic      chip_sel_n,
   input  wire logic      out_gate_n,
   input  wire logic      wr_strobe_n,
   input  wire fhc_byte_t dq_i,
   input  wire logic      host_oe,
   input  wire logic      reset_unprotect_n,
   output var fhc_byte_t  dq_o,
   output wire logic      dq_oe,
   output var logic       busy_indicator_n,
   // high-voltage qualifiers, one per pin
   input  wire logic      sig_addr_hv,
   input  wire logic      out_gate_hv,
   input  wire logic      chip_sel_hv,
   input  wire logic      reset_hv,
   // sticky flag: both sides drove the data pins
   output var logic       bad
);
   timeunit 1ns;
   timeprecision 100ps;
   fhc_byte_t mem [int];
   logic      prot [64];
   fhc_addr_t lat_a;
   fhc_byte_t lat_d;
   fhc_byte_t last_r;
   int        st;
   logic      amode;
   logic      hv_prot;
   logic      hv_unprot;
   time       t_fall;

   initial begin
      foreach (prot[i]) prot[i] = 1'b0;
      st = 0;
      amode = 1'b0;
      busy_indicator_n = 1'b1;
      bad = 1'b0;
      last_r = 8'h00;
      dq_o = 8'hFF;
   end

   // array, signature or protect status
   function automatic fhc_byte_t rd(fhc_addr_t a);
      if (sig_addr_hv || amode) begin
         if (!a[1])
            return a[0] ? PART_CODE : MAKER_CODE;
         return {7'h00, prot[a[18:13]]};
      end
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction

   // drives only when selected and gated; releases the pins while deselected
   assign dq_oe = !chip_sel_n && !out_gate_n && !out_gate_hv && !chip_sel_hv && reset_unprotect_n;

   // released pins show the inverse of the last byte, never a held value
   always @(addr or dq_oe or amode or sig_addr_hv) begin
      if (dq_oe) begin
         dq_o = rd(addr);
         last_r = dq_o;
      end else
         dq_o = ~last_r;
   end

   // delayed look so same-step edge ordering cannot false-flag
   always @(dq_oe or host_oe) #1 if (dq_oe && host_oe) bad = 1'b1;

   // data kept only while the host drives, so a late release is harmless
   always @(dq_i or host_oe) if (host_oe) lat_d = dq_i;

   // address on the later falling strobe
   always @(negedge wr_strobe_n or negedge chip_sel_n)
      if (!wr_strobe_n && !chip_sel_n)
         lat_a = addr;

   // data on the earlier rising strobe, only with output gate high
   always @(posedge wr_strobe_n or posedge chip_sel_n)
      if ((wr_strobe_n ^ chip_sel_n) && out_gate_n && !out_gate_hv && reset_unprotect_n)
         cmd(lat_a, lat_d);

   // protect and unprotect are judged on the strobe width
   always @(negedge wr_strobe_n) begin
      t_fall = $time;
      hv_prot = sig_addr_hv && out_gate_hv && !chip_sel_hv;
      hv_unprot = sig_addr_hv && out_gate_hv && chip_sel_hv && addr[12] && addr[15];
      lat_a = addr;
   end
   always @(posedge wr_strobe_n) begin
      if (hv_prot && $time - t_fall >= PROT_NS)
         prot[lat_a[18:13]] = 1'b1;
      if (hv_unprot && $time - t_fall >= UNPROT_NS)
         foreach (prot[i]) prot[i] = 1'b0;
   end

   // command interface: unlock pair, set-up, then operands
   task automatic cmd(fhc_addr_t a, fhc_byte_t d);
      logic k1;
      logic k2;
      int   q[$];
      k1 = (a == `FHC_UNLOCK1_ADDR) && (d == `FHC_UNLOCK1_DATA);
      k2 = (a == `FHC_UNLOCK2_ADDR) && (d == `FHC_UNLOCK2_DATA);
      amode = 1'b0;
      if (st == 2 && a == `FHC_UNLOCK1_ADDR && d == `FHC_CMD_AUTOSEL)
         amode = 1'b1;
      if (st == 3 && busy_indicator_n && !(prot[a[18:13]] && !reset_hv)) begin
         mem[a] = rd(a) & d;
         busy_indicator_n <= 1'b0;
         busy_indicator_n <= #(BUSY_NS) 1'b1;
      end
      if (st == 6 && busy_indicator_n) begin
         foreach (mem[i])
            if ((d == `FHC_CMD_CHIP_CONF || (d == `FHC_CMD_BLOCK_CONF && i[18:13] == a[18:13]))
                && !(prot[i[18:13]] && !reset_hv))
               q.push_back(i);
         foreach (q[j]) mem.delete(q[j]);
      end
      case (st)
         1: st = k2 ? 2 : 0;
         2: st = (a != `FHC_UNLOCK1_ADDR) ? 0 : (d == `FHC_CMD_PROGRAM) ? 3 : (d == `FHC_CMD_ERASE_SETUP) ? 4 : 0;
         4: st = k1 ? 5 : 0;
         5: st = k2 ? 6 : 0;
         default: st = (st != 3 && st != 6 && k1) ? 1 : 0;
      endcase
   endtask
endmodule
`default_nettype wire

/* File: test/fhc_host_tb.sv */
`include "fhc_defines.svh"
`default_nettype none
// bench: user-side requests against the host and the pin-level flash model
module fhc_host_tb
   import fhc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam fhc_byte_t MAKER  = 8'h5A; // arbitrary value
   localparam fhc_byte_t PART   = 8'hC3; // arbitrary value
   localparam fhc_addr_t ADDR_P = 19'h02304; // block 1, low bits clear
   localparam fhc_addr_t ADDR_Q = 19'h40010; // block 32
   logic      clock, sys_rst, req_valid, req_ready, temp_unprotect, rsp_valid, busy;
   fhc_op_e   req_op;
   fhc_addr_t req_addr, addr;
   fhc_byte_t req_data, rsp_data, byte_lanes_o, byte_lanes_i, dev_o, got;
   logic      chip_sel_n, out_gate_n, wr_strobe_n, byte_lanes_oe, dev_oe, reset_unprotect_n;
   logic      busy_indicator_n, sig_addr_hv, out_gate_hv, chip_sel_hv, reset_hv, bad;
   int        fail_count, checked, cycles;

   // wire level: whoever drives wins, the model shows junk when released
   assign byte_lanes_i = byte_lanes_oe ? byte_lanes_o : dev_o;

   // short protect counts keep the run brief
   fhc_host #(.PROTECT_CYC(24'h000014), .UNPROTECT_CYC(24'h000014)) dut (
      .clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
      .req_addr(req_addr), .req_data(req_data), .temp_unprotect(temp_unprotect), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .busy(busy), .addr(addr), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
      .wr_strobe_n(wr_strobe_n), .byte_lanes_o(byte_lanes_o), .byte_lanes_oe(byte_lanes_oe),
      .byte_lanes_i(byte_lanes_i), .reset_unprotect_n(reset_unprotect_n), .busy_indicator_n(busy_indicator_n),
      .sig_addr_hv(sig_addr_hv), .out_gate_hv(out_gate_hv), .chip_sel_hv(chip_sel_hv), .reset_hv(reset_hv));
   fhc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) mdl (
      .addr(addr), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n),
      .dq_i(byte_lanes_i), .host_oe(byte_lanes_oe), .reset_unprotect_n(reset_unprotect_n), .dq_o(dev_o),
      .dq_oe(dev_oe), .busy_indicator_n(busy_indicator_n), .sig_addr_hv(sig_addr_hv),
      .out_gate_hv(out_gate_hv), .chip_sel_hv(chip_sel_hv), .reset_hv(reset_hv), .bad(bad));

   always #5 clock = ~clock;

   // hang guard, well above the fewer than two thousand cycles the tests need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(string what, fhc_byte_t exp, fhc_byte_t seen);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // request held until taken, answer caught while its pulse stands
   task automatic op(fhc_op_e o, fhc_addr_t a, fhc_byte_t d);
      int n;
      @(negedge clock);
      req_valid = 1'b1;
      req_op = o;
      req_addr = a;
      req_data = d;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
      @(negedge clock);
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(negedge clock);
         n++;
      end
      got = rsp_data;
      if (n == 2000)
         chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
   endtask

   task automatic rd_chk(string what, fhc_op_e o, fhc_addr_t a, fhc_byte_t exp);
      op(o, a, 8'h00);
      chk(what, exp, got);
   endtask

   // lets the busy synchroniser catch up, then waits out the device
   task automatic idle();
      int n;
      repeat (6) @(negedge clock);
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(negedge clock);
         n++;
      end
   endtask

   initial begin
      clock = 1'b0;
      sys_rst = 1'b1;
      req_valid = 1'b0;
      req_op = FHC_OP_READ;
      req_addr = 19'h00000;
      req_data = 8'h00;
      temp_unprotect = 1'b0;
      fail_count = 0;
      checked = 0;
      cycles = 0;
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
      chk("req_ready", 8'h01, {7'h00, req_ready});
      chk("strobes", 8'h07, {5'h00, chip_sel_n, out_gate_n, wr_strobe_n});
      // second program lands while the first is still running
      op(FHC_OP_PROGRAM, ADDR_P, 8'h3C);
      op(FHC_OP_PROGRAM, ADDR_Q, 8'h96);
      chk("busy", 8'h01, {7'h00, busy});
      idle();
      rd_chk("array", FHC_OP_READ, ADDR_P, 8'h3C);
      rd_chk("refused", FHC_OP_READ, ADDR_Q, 8'hFF);
      op(FHC_OP_PROGRAM, ADDR_Q, 8'h96);
      idle();
      rd_chk("sig maker", FHC_OP_SIG_READ, 19'h7FFFC, MAKER);
      rd_chk("sig part", FHC_OP_SIG_READ, 19'h00001, PART);
      op(FHC_OP_AUTOSEL, 19'h00000, 8'h00);
      rd_chk("asel maker", FHC_OP_READ, 19'h00000, MAKER);
      rd_chk("asel part", FHC_OP_READ, 19'h00001, PART);
      rd_chk("asel status", FHC_OP_READ, ADDR_P | 19'h00002, 8'h00);
      op(FHC_OP_WRITE, 19'h00000, 8'h00);
      rd_chk("abandoned", FHC_OP_READ, ADDR_P, 8'h3C);
      op(FHC_OP_PROTECT, ADDR_P, 8'h00);
      rd_chk("protected", FHC_OP_PROT_VERIFY, ADDR_P | 19'h00002, 8'h01);
      op(FHC_OP_AUTOSEL, 19'h00000, 8'h00);
      rd_chk("asel protected", FHC_OP_READ, ADDR_P | 19'h00002, 8'h01);
      op(FHC_OP_RESET_ARRAY, 19'h00000, 8'h00);
      rd_chk("reset array", FHC_OP_READ, ADDR_P, 8'h3C);
      op(FHC_OP_PROGRAM, ADDR_P + 19'h00001, 8'h11);
      idle();
      rd_chk("locked", FHC_OP_READ, ADDR_P + 19'h00001, 8'hFF);
      temp_unprotect = 1'b1;
      op(FHC_OP_PROGRAM, ADDR_P + 19'h00001, 8'h11);
      idle();
      temp_unprotect = 1'b0;
      rd_chk("temp unprotect", FHC_OP_READ, ADDR_P + 19'h00001, 8'h11);
      rd_chk("restored", FHC_OP_PROT_VERIFY, ADDR_P | 19'h00002, 8'h01);
      op(FHC_OP_BLOCK_ERASE, ADDR_P, 8'h00);
      idle();
      rd_chk("erase locked", FHC_OP_READ, ADDR_P, 8'h3C);
      op(FHC_OP_UNPROTECT, ADDR_P | 19'h09000, 8'h00);
      rd_chk("unprotected", FHC_OP_UNPROT_VERIFY, ADDR_P | 19'h00042, 8'h00);
      op(FHC_OP_BLOCK_ERASE, ADDR_P, 8'h00);
      idle();
      rd_chk("erased", FHC_OP_READ, ADDR_P, 8'hFF);
      rd_chk("other block", FHC_OP_READ, ADDR_Q, 8'h96);
      op(FHC_OP_SUSPEND, ADDR_Q, 8'h00);
      op(FHC_OP_RESUME, ADDR_Q, 8'h00);
      op(FHC_OP_CHIP_ERASE, 19'h00000, 8'h00);
      idle();
      rd_chk("chip erased", FHC_OP_READ, ADDR_Q, 8'hFF);
      chk("bus fight", 8'h00, {7'h00, bad});
      end_sim();
   end
endmodule
`default_nettype wire
